// *** rtl/ssp_spi_port.sv ***
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/10ps
module ssp_spi_port (
    input  wire logic       clk_sys_i,    // 20 MHz system clock
    input  wire logic       rst_n_i,      // Async reset, active low
    input  wire logic [2:0] addr_i,       // Register address
    input  wire logic [7:0] wdata_i,      // Write data
    input  wire logic       wr_i,         // Write strobe
    input  wire logic       rd_i,         // Read strobe
    output logic      [7:0] rdata_o,      // Read data, cycle after strobe
    output logic            irq_o,        // Level interrupt
    input  wire logic       sub_tick_i,   // Sub clock half-period tick
    input  wire logic       tmr_match_i,  // Timer match pulse
    input  wire logic       sdi_i,        // Serial data in
    output logic            sdo_o,        // Serial data out
    output logic            sck_o,        // Serial clock out
    output logic            sck_oe_n_o,   // Clock drive enable, low drives
    input  wire logic       sck_i,        // Serial clock in (slave)
    input  wire logic       sel_n_i       // Select line in, slave
);
    typedef enum logic [1:0] {SSP_IDLE, SSP_LEAD, SSP_TRAIL} ssp_state_t;

    ssp_state_t  st_reg, st_next;
    logic [7:0]  c1_reg, c1_next, c2_reg, c2_next;
    logic [7:0]  sh_reg, sh_next, rd_reg, rd_next;
    logic [7:0]  mask_reg, mask_next;
    logic [1:0]  ist_reg, ist_next;
    logic [3:0]  cnt_reg, cnt_next;
    logic [5:0]  div_reg, div_next;
    logic        sck_reg, sck_next, sdo_reg, sdo_next;
    logic        mem_we;
    logic [7:0]  mem_wdata, mem_q;
    logic        s_rise, s_fall, sel_rise, sel_fall;

    wire logic [2:0] mode     = c1_reg[ssp_pkg::C1_MODE_LSB +: 3];
    wire logic       enable   = c1_reg[ssp_pkg::C1_ENABLE];
    wire logic       cpol_low = c2_reg[ssp_pkg::C2_CPOL];
    wire logic       spi_sel  = !c1_reg[ssp_pkg::C1_UART]
                                && (mode <= ssp_pkg::MODE_SLAVE);
    wire logic       is_slave = (mode == ssp_pkg::MODE_SLAVE);
    wire logic       idle_lvl = ~cpol_low;
    // Edge select set means capture on the edge that leaves the idle level
    wire logic       cap_lead = c2_reg[ssp_pkg::C2_CEDGE];
    wire logic       sel_ok   = !c2_reg[ssp_pkg::C2_SELEN] || !sel_n_i;
    wire logic       wr_data  = wr_i && addr_i == ssp_pkg::ADDR_DATA && spi_sel;
    wire logic       busy     = (st_reg != SSP_IDLE);

    function automatic logic out_bit(input logic [7:0] v, input logic msbf);
        out_bit = msbf ? v[7] : v[0];
    endfunction : out_bit

    function automatic logic [7:0] shift_in(input logic [7:0] v, input logic msbf,
                                            input logic b);
        shift_in = msbf ? {v[6:0], b} : {b, v[7:1]};
    endfunction : shift_in

    ssp_edge_det u_sck_edge (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .lvl_i     (sck_i),
        .rise_o    (s_rise),
        .fall_o    (s_fall)
    );

    ssp_edge_det u_sel_edge (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .lvl_i     (sel_n_i),
        .rise_o    (sel_rise),
        .fall_o    (sel_fall)
    );

    ssp_data_mem u_data (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .we_i      (mem_we),
        .wdata_i   (mem_wdata),
        .rdata_o   (mem_q)
    );

    // Half-period tick for master clock by mode
    logic tick;
    always_comb begin
        tick = 1'b0;
        if (mode == ssp_pkg::MODE_SUB) begin
            tick = sub_tick_i;
        end else if (mode == ssp_pkg::MODE_TIMER) begin
            tick = tmr_match_i; // Toggling per match gives half rate
        end else if (mode == ssp_pkg::MODE_DIV4) begin
            tick = (div_reg >= ssp_pkg::HALF_DIV4);
        end else if (mode == ssp_pkg::MODE_DIV16) begin
            tick = (div_reg >= ssp_pkg::HALF_DIV16);
        end else begin
            tick = (div_reg >= ssp_pkg::HALF_DIV64);
        end
    end

    // Leading/trailing clock edge events for the current role
    logic lead_ev, trail_ev;
    always_comb begin
        if (is_slave) begin
            lead_ev  = idle_lvl ? s_fall : s_rise;
            trail_ev = idle_lvl ? s_rise : s_fall;
        end else begin
            lead_ev  = (st_reg == SSP_LEAD) && tick;
            trail_ev = (st_reg == SSP_TRAIL) && tick;
        end
    end

    always_comb begin
        st_next   = st_reg;
        c1_next   = c1_reg;
        c2_next   = c2_reg;
        sh_next   = sh_reg;
        cnt_next  = cnt_reg;
        mask_next = mask_reg;
        ist_next  = ist_reg;
        sck_next  = idle_lvl;
        sdo_next  = sdo_reg;
        div_next  = (busy && !is_slave && !tick) ? div_reg + 6'h01 : 6'h00;
        mem_we    = 1'b0;
        mem_wdata = sh_reg;
        rd_next   = 8'h00;
        if (wr_i) begin
            if (addr_i == ssp_pkg::ADDR_CTRL1) begin
                c1_next = wdata_i;
            end else if (addr_i == ssp_pkg::ADDR_CTRL2 && spi_sel) begin
                c2_next = wdata_i;
            end else if (addr_i == ssp_pkg::ADDR_IRQ_MK) begin
                mask_next = wdata_i;
            end
        end
        if (rd_i) begin
            if (addr_i == ssp_pkg::ADDR_CTRL1) begin
                rd_next = c1_reg;
            end else if (addr_i == ssp_pkg::ADDR_CTRL2 && spi_sel) begin
                rd_next = c2_reg;
            end else if (addr_i == ssp_pkg::ADDR_DATA && spi_sel) begin
                rd_next = mem_q;
            end else if (addr_i == ssp_pkg::ADDR_IRQ_ST) begin
                rd_next  = {6'h00, ist_reg};
                ist_next = 2'h0; // Read clears; a same-cycle event still sets
            end
        end
        if (wr_data) begin
            if (busy) begin
                c2_next[ssp_pkg::C2_WRITE_COLLISION_FLAG] = 1'b1;
            end else begin
                mem_we    = 1'b1;
                mem_wdata = wdata_i;
                sh_next   = wdata_i;
                sdo_next  = out_bit(wdata_i, c2_reg[ssp_pkg::C2_MSBF]);
                cnt_next  = 4'h0;
                if (enable && !is_slave) begin
                    st_next = SSP_LEAD;
                end
            end
        end
        if (!enable || !spi_sel) begin
            st_next = SSP_IDLE;
        end else if (is_slave && !busy && sel_ok && !wr_data) begin
            if (lead_ev || trail_ev) begin
                st_next = SSP_LEAD;
            end
        end
        if (enable && spi_sel && (busy || is_slave && sel_ok)) begin
            if (!is_slave) begin
                // Edge leaves with the event, so capture sees pre-edge data
                sck_next = (st_reg == SSP_TRAIL) ? ~idle_lvl : idle_lvl;
                if (lead_ev) begin
                    st_next  = SSP_TRAIL;
                    sck_next = ~idle_lvl;
                end else if (trail_ev) begin
                    st_next  = SSP_LEAD;
                    sck_next = idle_lvl;
                end
            end
            if ((lead_ev && cap_lead) || (trail_ev && !cap_lead)) begin
                sh_next  = shift_in(sh_reg, c2_reg[ssp_pkg::C2_MSBF], sdi_i);
                cnt_next = cnt_reg + 4'h1;
                if (cnt_reg == ssp_pkg::BITS_PER_XFER - 4'h1) begin
                    mem_we    = 1'b1;
                    mem_wdata = shift_in(sh_reg, c2_reg[ssp_pkg::C2_MSBF], sdi_i);
                    // Master on leading capture still owes the last trailing edge
                    if (is_slave || trail_ev) begin
                        st_next   = SSP_IDLE;
                        ist_next[0] = 1'b1;
                        c2_next[ssp_pkg::C2_DONE] = 1'b1;
                    end
                end
            end else if (lead_ev || trail_ev) begin
                sdo_next = out_bit(sh_reg, c2_reg[ssp_pkg::C2_MSBF]);
                if (!is_slave && cnt_reg == ssp_pkg::BITS_PER_XFER) begin
                    st_next     = SSP_IDLE;
                    ist_next[0] = 1'b1;
                    c2_next[ssp_pkg::C2_DONE] = 1'b1;
                end
            end
        end
        if (is_slave && busy && c2_reg[ssp_pkg::C2_SELEN] && sel_rise && enable) begin
            st_next = SSP_IDLE;
            ist_next = 2'h3;
            c1_next[ssp_pkg::C1_INCOMP] = 1'b1;
            c2_next[ssp_pkg::C2_DONE]   = 1'b1;
        end
        if (is_slave && sel_fall && c2_reg[ssp_pkg::C2_SELEN]) begin
            cnt_next = 4'h0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg   <= SSP_IDLE;
            c1_reg   <= ssp_pkg::CTRL1_RST;
            c2_reg   <= ssp_pkg::CTRL2_RST;
            sh_reg   <= 8'h00;
            cnt_reg  <= 4'h0;
            div_reg  <= 6'h00;
            mask_reg <= 8'h00;
            ist_reg  <= 2'h0;
            sck_reg  <= 1'b1;
            sdo_reg  <= 1'b0;
            rd_reg   <= 8'h00;
        end else begin
            st_reg   <= st_next;
            c1_reg   <= c1_next;
            c2_reg   <= c2_next;
            sh_reg   <= sh_next;
            cnt_reg  <= cnt_next;
            div_reg  <= div_next;
            mask_reg <= mask_next;
            ist_reg  <= ist_next;
            sck_reg  <= sck_next;
            sdo_reg  <= sdo_next;
            rd_reg   <= rd_next;
        end
    end

    assign rdata_o    = rd_reg;
    assign sck_o      = sck_reg;
    assign sck_oe_n_o = !(enable && spi_sel && !is_slave);
    assign sdo_o      = sdo_reg;
    assign irq_o      = |(ist_reg & mask_reg[1:0]);

    property p_write_collision_flag;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (wr_data && busy) |=> c2_reg[ssp_pkg::C2_WRITE_COLLISION_FLAG];
    endproperty
    a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision flag not set");

    property p_idle_clk;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (!enable) |=> (sck_reg == idle_lvl);
    endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("clock not idle");

    property p_start;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (wr_data && !busy && enable && !is_slave) |=> (st_reg == SSP_LEAD);
    endproperty
    a_start: assert property (p_start) else $error("master did not start");

    property p_incomp;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (is_slave && busy && enable && c2_reg[ssp_pkg::C2_SELEN] && sel_rise)
        |=> (c1_reg[ssp_pkg::C1_INCOMP] && c2_reg[ssp_pkg::C2_DONE]);
    endproperty
    a_incomp: assert property (p_incomp) else $error("incomplete not flagged");

    property p_gate;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (wr_i && addr_i == ssp_pkg::ADDR_CTRL2 && !spi_sel) |=> $stable(c2_reg);
    endproperty
    a_gate: assert property (p_gate) else $error("ctrl2 written outside SPI");

    property p_oe;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        is_slave |-> sck_oe_n_o;
    endproperty
    a_oe: assert property (p_oe) else $error("slave drives clock");

    property p_cnt;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        cnt_reg <= ssp_pkg::BITS_PER_XFER;
    endproperty
    a_cnt: assert property (p_cnt) else $error("bit counter overflow");

    property p_busyidle;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (!spi_sel) |=> (st_reg == SSP_IDLE);
    endproperty
    a_busyidle: assert property (p_busyidle) else $error("busy outside SPI");

    property p_done_sticky;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (c2_reg[ssp_pkg::C2_DONE] && !(wr_i && addr_i == ssp_pkg::ADDR_CTRL2))
        |=> c2_reg[ssp_pkg::C2_DONE];
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("done flag lost");

    property p_write_collision_flag_sticky;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (c2_reg[ssp_pkg::C2_WRITE_COLLISION_FLAG] && !(wr_i && addr_i == ssp_pkg::ADDR_CTRL2))
        |=> c2_reg[ssp_pkg::C2_WRITE_COLLISION_FLAG];
    endproperty
    a_write_collision_flag_sticky: assert property (p_write_collision_flag_sticky) else $error("collision flag lost");

    property p_sel_gate;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (is_slave && c2_reg[ssp_pkg::C2_SELEN] && sel_n_i && !busy) |=> (st_reg == SSP_IDLE);
    endproperty
    a_sel_gate: assert property (p_sel_gate) else $error("slave started unselected");
endmodule : ssp_spi_port

// *** shared/ssp_pkg.sv ***
// Overview of operation
// - Mode bits pick UART, SPI or I2C
// - Four pins: data in, out, clock, select
// - Master starts transfers and drives clock
// - Shift out and in at once
// - Select pin used only when enabled
// - Bit order LSB or MSB first
// - Capture edge rising or falling selectable
// - Second control and data need SPI mode
// - First control register bit layout
// - Second control register bit layout
// - Mode field decode: masters, slave, I2C
// - Idle polarity and capture edge setting
// - Busy data write ignored, sets collision
// - Early deselect flags incomplete and done
package ssp_pkg;
    localparam logic [2:0] ADDR_CTRL1  = 3'h0;
    localparam logic [2:0] ADDR_CTRL2  = 3'h1;
    localparam logic [2:0] ADDR_DATA   = 3'h2;
    localparam logic [2:0] ADDR_IRQ_ST = 3'h3;
    localparam logic [2:0] ADDR_IRQ_MK = 3'h4;
    localparam logic [7:0] CTRL1_RST   = 8'he0;
    localparam logic [7:0] CTRL2_RST   = 8'h00;
    localparam int C1_MODE_LSB = 5;
    localparam int C1_UART     = 4;
    localparam int C1_ENABLE   = 1;
    localparam int C1_INCOMP   = 0;
    localparam int C2_CPOL     = 5;
    localparam int C2_CEDGE    = 4;
    localparam int C2_MSBF     = 3;
    localparam int C2_SELEN    = 2;
    localparam int C2_WRITE_COLLISION_FLAG     = 1;
    localparam int C2_DONE     = 0;
    localparam logic [2:0] MODE_DIV4   = 3'h0;
    localparam logic [2:0] MODE_DIV16  = 3'h1;
    localparam logic [2:0] MODE_DIV64  = 3'h2;
    localparam logic [2:0] MODE_SUB    = 3'h3;
    localparam logic [2:0] MODE_TIMER  = 3'h4;
    localparam logic [2:0] MODE_SLAVE  = 3'h5;
    localparam logic [5:0] HALF_DIV4   = 6'h01;
    localparam logic [5:0] HALF_DIV16  = 6'h07;
    localparam logic [5:0] HALF_DIV64  = 6'h1f;
    localparam logic [3:0] BITS_PER_XFER = 4'h8;
endpackage : ssp_pkg

// *** rtl/ssp_data_mem.sv ***
`timescale 1ns/10ps
// Data byte holder with registered read-back
module ssp_data_mem (
    input  wire logic       clk_sys_i,  // System clock
    input  wire logic       rst_n_i,    // Async reset
    input  wire logic       we_i,       // Write enable
    input  wire logic [7:0] wdata_i,    // Write data
    output logic      [7:0] rdata_o     // Stored byte
);
    logic [7:0] mem_reg;
    logic [7:0] mem_next;

    always_comb begin
        mem_next = we_i ? wdata_i : mem_reg;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_reg <= 8'h00;
        end else begin
            mem_reg <= mem_next;
        end
    end

    assign rdata_o = mem_reg;
endmodule : ssp_data_mem

// *** rtl/ssp_edge_det.sv ***
`timescale 1ns/10ps
// Edge detector on a synchronous input level
module ssp_edge_det (
    input  wire logic clk_sys_i,  // System clock
    input  wire logic rst_n_i,    // Async reset
    input  wire logic lvl_i,      // Level to watch
    output logic      rise_o,     // Rising edge pulse
    output logic      fall_o      // Falling edge pulse
);
    logic prev_reg;
    logic prev_next;

    always_comb begin
        prev_next = lvl_i;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_reg <= 1'b1; // Watched pins idle high; avoids a false edge after reset
        end else begin
            prev_reg <= prev_next;
        end
    end

    assign rise_o = lvl_i & ~prev_reg;
    assign fall_o = ~lvl_i & prev_reg;
endmodule : ssp_edge_det

// *** test/ssp_peer_slave.sv ***
`timescale 1ns/10ps
// Behavioural single slave on the far side of the master port
module ssp_peer_slave (
    input  wire logic       sck_i,       // Bus clock from master
    input  wire logic       mosi_i,      // Master data out
    input  wire logic       sel_n_i,     // GPIO-driven select, low active
    input  wire logic       cap_rise_i,  // Capture on rising edge
    input  wire logic       msb_i,       // MSB first
    input  wire logic [7:0] tx_i,        // Byte returned to master
    output logic            miso_o,      // Data to master
    output logic      [7:0] rx_o         // Byte captured
);
    int cnt = 0;
    function automatic logic pick(input int i);
        return msb_i ? tx_i[7-i] : tx_i[i];
    endfunction : pick
    initial miso_o = 1'b0;
    always @(negedge sel_n_i) begin
        cnt = 0;
        miso_o = pick(0);
    end
    // Released line must not keep a stale bit
    always @(posedge sel_n_i) miso_o = ~miso_o;
    always @(sck_i) begin
        if (!sel_n_i) begin
            if (sck_i == cap_rise_i) begin
                rx_o = msb_i ? {rx_o[6:0], mosi_i} : {mosi_i, rx_o[7:1]};
                cnt = cnt + 1;
            end else if (cnt < 8) begin
                miso_o = pick(cnt);
            end
        end
    end
endmodule : ssp_peer_slave

// *** test/ssp_spi_port_bench.sv ***
`timescale 1ns/10ps
module ssp_spi_port_bench;
    logic       clk_sys_i = 0;
    logic       rst_n_i   = 0;
    logic       wr_i      = 0;
    logic       rd_i      = 0;
    logic       sub_tick_i = 0;
    logic       tmr_match_i = 0;
    logic [2:0] addr_i    = '0;
    logic [7:0] wdata_i   = '0;
    logic [7:0] rdata_o, peer_tx = 8'h00, peer_rx;
    logic       irq_o, sdo_o, sck_o, sck_oe_n_o, peer_sdo, sck_q = 1;
    logic       m_sdi = 0, m_sck = 1, m_sel_n = 1, slave_run = 0, g_sel_n = 1;
    logic       cap_rise = 0, msb = 0;
    int         n_mismatch = 0, n_tests = 0, cyc = 0, n_edge = 0, t_first = 0, t_last = 0;

    always #25 clk_sys_i = ~clk_sys_i;

    ssp_spi_port dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
        .sub_tick_i(sub_tick_i), .tmr_match_i(tmr_match_i),
        .sdi_i(slave_run ? m_sdi : peer_sdo), .sdo_o(sdo_o), .sck_o(sck_o),
        .sck_oe_n_o(sck_oe_n_o), .sck_i(slave_run ? m_sck : sck_o),
        .sel_n_i(slave_run ? m_sel_n : 1'b1));
    ssp_peer_slave peer (.sck_i(sck_o), .mosi_i(sdo_o), .sel_n_i(g_sel_n),
        .cap_rise_i(cap_rise), .msb_i(msb), .tx_i(peer_tx), .miso_o(peer_sdo), .rx_o(peer_rx));

    // Tick sources, serial clock edge log and run limit
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        sub_tick_i <= (cyc % 5 == 4);
        tmr_match_i <= (cyc % 7 == 6);
        sck_q <= sck_o;
        if (sck_o !== sck_q) begin
            if (n_edge == 0) t_first <= cyc;
            t_last <= cyc;
            n_edge <= n_edge + 1;
        end
        if (cyc == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : reg_rd

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        reg_rd(a, d);
        check(d, exp);
    endtask : rd_chk

    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge clk_sys_i);
        #1 check({7'h0, irq_o}, {7'h0, exp});
    endtask : irq_chk

    task automatic reg_test();
        logic [7:0] bad [3] = '{8'he2, 8'hc2, 8'h12};
        rd_chk(ssp_pkg::ADDR_CTRL1, 8'he0);
        rd_chk(ssp_pkg::ADDR_CTRL2, 8'h00);
        for (int i = 0; i < 3; i++) begin
            reg_wr(ssp_pkg::ADDR_CTRL1, bad[i]);
            reg_wr(ssp_pkg::ADDR_CTRL2, 8'h38);
            rd_chk(ssp_pkg::ADDR_DATA, 8'h00);
            reg_wr(ssp_pkg::ADDR_CTRL1, 8'h02);
            rd_chk(ssp_pkg::ADDR_CTRL2, 8'h00);
        end
        rd_chk(3'h5, 8'h00);
        reg_wr(ssp_pkg::ADDR_CTRL2, 8'hfc);
        rd_chk(ssp_pkg::ADDR_CTRL2, 8'hfc);
        reg_wr(ssp_pkg::ADDR_CTRL1, 8'hae);
        rd_chk(ssp_pkg::ADDR_CTRL1, 8'hae);
    endtask : reg_test

    task automatic master_xfer(input logic [2:0] mode, input int half, input logic cp,
                               input logic ce, input logic ms, input logic [7:0] tx,
                               input logic [7:0] ptx, input logic coll);
        logic [7:0] d;
        cap_rise = (cp == ce);
        msb = ms;
        peer_tx = ptx;
        reg_wr(ssp_pkg::ADDR_CTRL1, {mode, 5'h02});
        reg_wr(ssp_pkg::ADDR_CTRL2, {2'h0, cp, ce, ms, 3'h0});
        rd_chk(ssp_pkg::ADDR_CTRL2, {2'h0, cp, ce, ms, 3'h0});
        check({7'h0, sck_o}, {7'h0, ~cp});
        g_sel_n = 1'b0;
        n_edge = 0;
        reg_wr(ssp_pkg::ADDR_DATA, tx);
        if (coll) begin
            reg_wr(ssp_pkg::ADDR_DATA, ~tx);
            check({7'h0, sck_oe_n_o}, 8'h00);
        end
        for (int k = 0; k < 400; k++) begin
            reg_rd(ssp_pkg::ADDR_CTRL2, d);
            if (d[0] === 1'b1) break;
        end
        check(d, {2'h0, cp, ce, ms, 1'b0, coll, 1'b1});
        check(n_edge[7:0], 8'h10);
        check(8'(t_last - t_first), 8'(15 * half));
        rd_chk(ssp_pkg::ADDR_DATA, ptx);
        check(peer_rx, tx);
        g_sel_n = 1'b1;
        check({7'h0, sck_o}, {7'h0, ~cp});
    endtask : master_xfer

    task automatic slave_xfer(input int nbits, input logic [7:0] mtx);
        slave_run = 1'b1;
        reg_wr(ssp_pkg::ADDR_CTRL1, 8'ha2);
        reg_wr(ssp_pkg::ADDR_CTRL2, 8'h0c);
        reg_wr(ssp_pkg::ADDR_DATA, 8'h5a);
        m_sel_n <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            repeat (4) @(posedge clk_sys_i);
            m_sck <= 1'b0;
            m_sdi <= mtx[7-i];
            repeat (4) @(posedge clk_sys_i);
            m_sck <= 1'b1;
        end
        repeat (4) @(posedge clk_sys_i);
        m_sel_n <= 1'b1;
        m_sdi <= ~m_sdi;
        repeat (4) @(posedge clk_sys_i);
        rd_chk(ssp_pkg::ADDR_CTRL1, (nbits == 8) ? 8'ha2 : 8'ha3);
        rd_chk(ssp_pkg::ADDR_CTRL2, 8'h0d);
        if (nbits == 8) rd_chk(ssp_pkg::ADDR_DATA, mtx);
        check({7'h0, sck_oe_n_o}, 8'h01);
    endtask : slave_xfer

    task automatic irq_test();
        rd_chk(ssp_pkg::ADDR_IRQ_ST, 8'h03);
        rd_chk(ssp_pkg::ADDR_IRQ_ST, 8'h00);
        slave_xfer(3, 8'h5a);
        reg_wr(ssp_pkg::ADDR_IRQ_MK, 8'h00);
        irq_chk(1'b0);
        reg_wr(ssp_pkg::ADDR_IRQ_MK, 8'h02);
        irq_chk(1'b1);
        reg_wr(ssp_pkg::ADDR_IRQ_MK, 8'h01);
        irq_chk(1'b1);
        rd_chk(ssp_pkg::ADDR_IRQ_ST, 8'h03);
        irq_chk(1'b0);
    endtask : irq_test

    initial begin
        repeat (6) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        reg_test();
        master_xfer(ssp_pkg::MODE_DIV4, 2, 0, 0, 1, 8'ha5, 8'h3c, 1);
        master_xfer(ssp_pkg::MODE_DIV4, 2, 0, 1, 0, 8'h81, 8'h7e, 0);
        master_xfer(ssp_pkg::MODE_DIV16, 8, 1, 0, 1, 8'h0f, 8'hc6, 0);
        master_xfer(ssp_pkg::MODE_DIV64, 32, 1, 1, 0, 8'h96, 8'h21, 0);
        master_xfer(ssp_pkg::MODE_SUB, 5, 0, 0, 0, 8'h5e, 8'hb4, 0);
        master_xfer(ssp_pkg::MODE_TIMER, 7, 1, 0, 1, 8'h3a, 8'h69, 0);
        slave_xfer(8, 8'hc3);
        slave_xfer(3, 8'h96);
        irq_test();
        end_of_test();
    end
endmodule : ssp_spi_port_bench
